//--- rtl/mii_phy_side_interface.sv
`timescale 1ns/100ps
`default_nettype none
`include "mii_defines.svh"

module mii_phy_side_interface (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        controller_enable_i,
    input  wire logic        interface_pin_select_i,
    input  wire logic        mii_mode_i,
    input  wire logic        full_duplex_i,
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_last_i,
    input  wire logic        tx_err_i,
    output logic             tx_ready_o,
    output logic             rx_valid_o,
    output logic [7:0]       rx_data_o,
    output logic             rx_end_o,
    output logic             rx_err_o,
    output logic             crs_o,
    output logic             col_o,
    input  wire logic        mgmt_start_i,
    input  wire logic        mgmt_read_i,
    input  wire logic [4:0]  mgmt_phy_i,
    input  wire logic [4:0]  mgmt_reg_i,
    input  wire logic [15:0] mgmt_wdata_i,
    output logic             mgmt_busy_o,
    output logic             mgmt_done_o,
    output logic [15:0]      mgmt_rdata_o,
    input  wire logic        tx_clk_i,
    output logic [3:0]       txd_o,
    output logic             tx_en_o,
    output logic             tx_en_oe_o,
    output logic             tx_er_o,
    output logic             pins_oe_o,
    input  wire logic        rx_clk_i,
    input  wire logic [3:0]  rxd_i,
    input  wire logic        rx_dv_i,
    input  wire logic        rx_er_i,
    input  wire logic        crs_i,
    input  wire logic        col_i,
    output logic             mdc_o,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    input  wire logic        mdio_i
);

    function automatic logic [3:0] unit_of(input logic [7:0] d,
                                           input logic       mii);
        unit_of = mii ? d[3:0] : {3'h0, d[0]};
    endfunction : unit_of

    function automatic logic [7:0] drop_unit(input logic [7:0] d,
                                             input logic       mii);
        drop_unit = mii ? {4'h0, d[7:4]} : {1'b0, d[7:1]};
    endfunction : drop_unit

    // system clock side
    mii_pkg::tx_word_t hold_q;
    logic              req_q;
    logic [1:0]        ack_s_q;
    logic              accept;
    logic [2:0]        rtog_s_q;
    logic [1:0]        crs_s_q;
    logic [1:0]        col_s_q;
    logic [1:0]        mdio_s_q;
    logic              pinsel_q;

    // transmit clock side
    logic [1:0]        trst_q;
    logic              trst_n;
    logic [1:0]        req_t_q;
    logic [1:0]        ten_t_q;
    logic [1:0]        mode_t_q;
    logic              ack_q;
    logic [7:0]        sh_q;
    logic [3:0]        units_q;
    logic              last_q;
    logic              load;

    // receive clock side
    logic [1:0]        rrst_q;
    logic              rrst_n;
    mii_pkg::rx_pins_t rxp1_q;
    mii_pkg::rx_pins_t rxp2_q;
    logic [1:0]        rps_q;
    logic [1:0]        rmode_q;
    logic              dv;
    logic              er;
    logic              dvp_q;
    logic              ferr_q;
    logic [7:0]        acc_q;
    logic [7:0]        acc_nx;
    logic [3:0]        cnt_q;
    logic [3:0]        cnt_nx;
    mii_pkg::rx_word_t rword_q;
    logic              rtog_q;

    // management
    mii_pkg::mgmt_state_t mg_q;
    logic [`MDC_DIV_W-1:0] div_q;
    logic [5:0]            bit_q;
    logic [63:0]           frame_q;
    logic                  rd_q;
    logic                  mdio_q;
    logic                  mdio_en_q;

    // transmit hand-off: one byte in flight, toggle handshake
    assign accept = tx_valid_i && tx_ready_o;

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            hold_q     <= '0;
            req_q      <= 1'b0;
            ack_s_q    <= 2'h0;
            tx_ready_o <= 1'b0;
        end
        else
        begin
            ack_s_q    <= {ack_s_q[0], ack_q};
            tx_ready_o <= !accept && controller_enable_i &&
                          (req_q == ack_s_q[1]);
            if (accept)
            begin
                hold_q <= '{data: tx_data_i, last: tx_last_i,
                            err: tx_err_i};
                req_q  <= ~req_q;
            end
        end
    end

    // pin ownership; undriven until selected
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            pinsel_q   <= 1'b0;
            pins_oe_o  <= 1'b0;
            tx_en_oe_o <= 1'b0;
        end
        else
        begin
            pinsel_q   <= interface_pin_select_i;
            pins_oe_o  <= interface_pin_select_i;
            tx_en_oe_o <= interface_pin_select_i;
        end
    end

    // carrier and collision pins into system clock
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            crs_s_q <= 2'h0;
            col_s_q <= 2'h0;
            crs_o   <= 1'b0;
            col_o   <= 1'b0;
        end
        else
        begin
            crs_s_q <= {crs_s_q[0], crs_i};
            col_s_q <= {col_s_q[0], col_i};
            crs_o   <= crs_s_q[1] && mii_mode_i;
            col_o   <= col_s_q[1] && !full_duplex_i;
        end
    end

    // transmit clock domain; it may stop while disabled
    always_ff @(posedge tx_clk_i)
    begin
        trst_q <= {trst_q[0], rstn_i};
    end
    assign trst_n = trst_q[1];

    always_ff @(posedge tx_clk_i)
    begin
        if (!trst_n)
        begin
            req_t_q  <= 2'h0;
            ten_t_q  <= 2'h0;
            mode_t_q <= 2'h0;
        end
        else
        begin
            req_t_q  <= {req_t_q[0], req_q};
            ten_t_q  <= {ten_t_q[0], controller_enable_i};
            mode_t_q <= {mode_t_q[0], mii_mode_i};
        end
    end

    // a frame's last unit always leaves tx_en low for one clock
    assign load = ten_t_q[1] && (req_t_q[1] != ack_q) &&
                  (units_q == 4'h0) && !(tx_en_o && last_q);

    always_ff @(posedge tx_clk_i)
    begin
        if (!trst_n)
        begin
            ack_q   <= 1'b0;
            sh_q    <= 8'h00;
            units_q <= 4'h0;
            last_q  <= 1'b0;
            txd_o   <= 4'h0;
            tx_en_o <= 1'b0;
            tx_er_o <= 1'b0;
        end
        else if (load)
        begin
            txd_o   <= unit_of(hold_q.data, mode_t_q[1]);
            sh_q    <= drop_unit(hold_q.data, mode_t_q[1]);
            units_q <= (mode_t_q[1] ? `MII_UNITS : `SER_UNITS) - 4'h1;
            tx_en_o <= 1'b1;
            tx_er_o <= hold_q.err && mode_t_q[1];
            last_q  <= hold_q.last;
            ack_q   <= ~ack_q;
        end
        else if (units_q != 4'h0)
        begin
            txd_o   <= unit_of(sh_q, mode_t_q[1]);
            sh_q    <= drop_unit(sh_q, mode_t_q[1]);
            units_q <= units_q - 4'h1;
        end
        else
        begin
            // end of frame, or source too slow: frame is cut short
            txd_o   <= 4'h0;
            tx_en_o <= 1'b0;
            tx_er_o <= 1'b0;
        end
    end

    AST_TX_SERIAL_LINES: assert property (
        @(posedge tx_clk_i) disable iff (!trst_n)
        (tx_en_o && !mode_t_q[1]) |-> (txd_o[3:1] == 3'h0))
        else $error("serial mode drove txd lines 1 to 3");

    AST_TX_IDLE_ZERO: assert property (
        @(posedge tx_clk_i) disable iff (!trst_n)
        !tx_en_o |-> (txd_o == 4'h0 && !tx_er_o))
        else $error("txd or tx_er active while tx_en low");

    AST_TX_HOLDS_EN: assert property (
        @(posedge tx_clk_i) disable iff (!trst_n)
        (tx_en_o && units_q != 4'h0) |=> tx_en_o)
        else $error("tx_en dropped inside a byte");

    AST_TX_END_DROP: assert property (
        @(posedge tx_clk_i) disable iff (!trst_n)
        (tx_en_o && last_q && units_q == 4'h0) |=> !tx_en_o)
        else $error("tx_en held after last nibble");

    AST_TX_LOW_FIRST: assert property (
        @(posedge tx_clk_i) disable iff (!trst_n)
        (load && mode_t_q[1]) |=>
            (txd_o == $past(hold_q.data[3:0])) ##1
            (txd_o == $past(hold_q.data[7:4], 2)))
        else $error("nibble order wrong");

    // receive clock domain
    always_ff @(posedge rx_clk_i)
    begin
        rrst_q <= {rrst_q[0], rstn_i};
    end
    assign rrst_n = rrst_q[1];

    always_ff @(posedge rx_clk_i)
    begin
        if (!rrst_n)
        begin
            rxp1_q  <= '0;
            rxp2_q  <= '0;
            rps_q   <= 2'h0;
            rmode_q <= 2'h0;
        end
        else
        begin
            rxp1_q  <= '{dv: rx_dv_i, er: rx_er_i, d: rxd_i};
            rxp2_q  <= rxp1_q;
            rps_q   <= {rps_q[0], pinsel_q};
            rmode_q <= {rmode_q[0], mii_mode_i};
        end
    end

    // unselected pins belong to other functions: treat as idle
    assign dv = rxp2_q.dv && rps_q[1];
    assign er = rxp2_q.er && rmode_q[1];
    assign acc_nx = rmode_q[1] ? {rxp2_q.d, acc_q[7:4]}
                               : {rxp2_q.d[0], acc_q[7:1]};
    assign cnt_nx = cnt_q + (rmode_q[1] ? `RX_NIB_STEP : `RX_BIT_STEP);

    always_ff @(posedge rx_clk_i)
    begin
        if (!rrst_n)
        begin
            dvp_q   <= 1'b0;
            ferr_q  <= 1'b0;
            acc_q   <= 8'h00;
            cnt_q   <= 4'h0;
            rword_q <= '0;
            rtog_q  <= 1'b0;
        end
        else
        begin
            dvp_q <= dv;
            if (dv)
            begin
                acc_q  <= acc_nx;
                ferr_q <= ferr_q || er;
                if (cnt_nx == `RX_BYTE_BITS)
                begin
                    cnt_q   <= 4'h0;
                    rword_q <= '{data: acc_nx, fin: 1'b0,
                                 err: ferr_q || er};
                    rtog_q  <= ~rtog_q;
                end
                else
                begin
                    cnt_q <= cnt_nx;
                end
            end
            else
            begin
                cnt_q  <= 4'h0;
                ferr_q <= 1'b0;
                if (dvp_q)
                begin
                    rword_q <= '{data: 8'h00, fin: 1'b1, err: ferr_q};
                    rtog_q  <= ~rtog_q;
                end
            end
        end
    end

    AST_RX_ER_IGNORED: assert property (
        @(posedge rx_clk_i) disable iff (!rrst_n)
        !dv |=> !ferr_q)
        else $error("rx_er counted while rx_dv low");

    AST_RX_NIBBLE: assert property (
        @(posedge rx_clk_i) disable iff (!rrst_n)
        (dv && rmode_q[1] && cnt_q == `RX_NIB_STEP) |=>
            (rword_q.data == {$past(rxp2_q.d), $past(acc_q[7:4])}))
        else $error("received nibbles misplaced");

    AST_RX_SERIAL_BIT: assert property (
        @(posedge rx_clk_i) disable iff (!rrst_n)
        (dv && !rmode_q[1] && cnt_q == 4'h7) |=>
            (rword_q.data[7] == $past(rxp2_q.d[0])))
        else $error("serial bit not taken from line 0");

    // words may come one rx clock apart: rx clock must stay <= 25 MHz
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            rtog_s_q   <= 3'h0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= 8'h00;
            rx_end_o   <= 1'b0;
            rx_err_o   <= 1'b0;
        end
        else
        begin
            rtog_s_q   <= {rtog_s_q[1:0], rtog_q};
            rx_valid_o <= rtog_s_q[2] != rtog_s_q[1];
            if (rtog_s_q[2] != rtog_s_q[1])
            begin
                rx_data_o <= rword_q.data;
                rx_end_o  <= rword_q.fin;
                rx_err_o  <= rword_q.err;
            end
        end
    end

    // management frame engine; no frame starts in serial mode
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            mg_q         <= mii_pkg::MG_IDLE;
            div_q        <= '0;
            bit_q        <= 6'h00;
            frame_q      <= 64'h0;
            rd_q         <= 1'b0;
            mdio_s_q     <= 2'h0;
            mdc_o        <= 1'b0;
            mdio_q       <= 1'b0;
            mdio_en_q    <= 1'b0;
            mgmt_busy_o  <= 1'b0;
            mgmt_done_o  <= 1'b0;
            mgmt_rdata_o <= 16'h0000;
        end
        else
        begin
            mdio_s_q    <= {mdio_s_q[0], mdio_i};
            mgmt_done_o <= 1'b0;
            case (mg_q)
                mii_pkg::MG_IDLE:
                begin
                    if (mgmt_start_i && mii_mode_i)
                    begin
                        frame_q <= {`MG_PREAMBLE, `MG_START,
                                    mgmt_read_i ? `MG_OP_READ
                                                : `MG_OP_WRITE,
                                    mgmt_phy_i, mgmt_reg_i, `MG_TA,
                                    mgmt_wdata_i};
                        rd_q        <= mgmt_read_i;
                        bit_q       <= 6'h00;
                        div_q       <= '0;
                        mdio_q      <= 1'b1;
                        mdio_en_q   <= 1'b1;
                        mgmt_busy_o <= 1'b1;
                        mg_q        <= mii_pkg::MG_SHIFT;
                    end
                end
                mii_pkg::MG_SHIFT:
                begin
                    if (div_q == `MDC_DIV_W'(`MDC_HALF_CYC - 1))
                    begin
                        div_q <= '0;
                        mdc_o <= ~mdc_o;
                        if (!mdc_o && rd_q && bit_q >= `MG_DATA_FIRST)
                        begin
                            mgmt_rdata_o <= {mgmt_rdata_o[14:0],
                                             mdio_s_q[1]};
                        end
                        if (mdc_o && bit_q == `MG_LAST_BIT)
                        begin
                            mdio_en_q <= 1'b0;
                            mg_q      <= mii_pkg::MG_DONE;
                        end
                        else if (mdc_o)
                        begin
                            // data moves only on the falling edge
                            bit_q     <= bit_q + 6'h01;
                            frame_q   <= {frame_q[62:0], 1'b0};
                            mdio_q    <= frame_q[62];
                            mdio_en_q <= !(rd_q &&
                                (bit_q + 6'h01) >= `MG_OWN_BITS);
                        end
                    end
                    else
                    begin
                        div_q <= div_q + `MDC_DIV_W'(1);
                    end
                end
                mii_pkg::MG_DONE:
                begin
                    mgmt_busy_o <= 1'b0;
                    mgmt_done_o <= 1'b1;
                    mg_q        <= mii_pkg::MG_IDLE;
                end
                default:
                begin
                    mg_q <= mii_pkg::MG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            mdio_o    <= 1'b0;
            mdio_oe_o <= 1'b0;
        end
        else
        begin
            mdio_o    <= mdio_q;
            mdio_oe_o <= mdio_en_q && pinsel_q;
        end
    end

    AST_MDIO_ON_FALL: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (mg_q == mii_pkg::MG_SHIFT && $changed(mdio_q)) |-> !mdc_o)
        else $error("mdio changed away from mdc falling edge");

    AST_MDC_HALF: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        (mg_q == mii_pkg::MG_SHIFT && $rose(mdc_o)) |=>
            (mdc_o [*8]))
        else $error("mdc high phase too short");

    AST_COL_FULL_DUPLEX: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        full_duplex_i |=> !col_o)
        else $error("collision reported in full duplex");

    AST_TXEN_UNDRIVEN: assert property (
        @(posedge mclk_i) disable iff (!rstn_i)
        !interface_pin_select_i ##1 !interface_pin_select_i
            |-> !tx_en_oe_o && !pins_oe_o)
        else $error("pins driven without pin select");

endmodule : mii_phy_side_interface

`default_nettype wire

//--- rtl/mii_defines.svh
`ifndef MII_DEFINES_SVH
`define MII_DEFINES_SVH

// system clock and management clock timing
`define CLK_PERIOD_NS  5
`define MDC_PERIOD_NS  400
// least half period of the management clock, rounded up
`define MDC_HALF_CYC \
    ((`MDC_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MDC_DIV_W      6

// management frame layout
`define MG_PREAMBLE    32'hFFFFFFFF
`define MG_START       2'h1
`define MG_OP_WRITE    2'h2
`define MG_OP_READ     2'h3
`define MG_TA          2'h2
`define MG_LAST_BIT    6'h3F
`define MG_OWN_BITS    6'h2E
`define MG_DATA_FIRST  6'h30

// link data units per byte
`define MII_UNITS      4'h2
`define SER_UNITS      4'h8
`define RX_NIB_STEP    4'h4
`define RX_BIT_STEP    4'h1
`define RX_BYTE_BITS   4'h8

`endif

//--- rtl/mii_pkg.sv
package mii_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       err;
    } tx_word_t;

    typedef struct packed {
        logic [7:0] data;
        logic       fin;
        logic       err;
    } rx_word_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] d;
    } rx_pins_t;

    typedef enum logic [1:0] {
        MG_IDLE  = 2'h0,
        MG_SHIFT = 2'h1,
        MG_DONE  = 2'h3
    } mgmt_state_t;

endpackage : mii_pkg

//--- tb/phy_model.sv
`timescale 1ns/100ps
`default_nettype none

module phy_model (
    input  wire logic       mode_i,
    input  wire logic [3:0] txd_i,
    input  wire logic       tx_en_i,
    input  wire logic       tx_er_i,
    input  wire logic       mdc_i,
    input  wire logic       mdio_o_i,
    input  wire logic       mdio_oe_i,
    output logic            tx_clk_o,
    output logic            rx_clk_o,
    output logic [3:0]      rxd_o,
    output logic            rx_dv_o,
    output logic            rx_er_o,
    output logic            mdio_o
);
    localparam logic [15:0] RD_VAL = 16'hC35A;
    logic [15:0] sh = 16'h0000;
    logic [15:0] wsh = 16'h0000;
    int          falls = 0;
    logic        hi_seen = 1'h0;
    logic        er_seen = 1'h0;
    int          units = 0;
    int          mcnt = 0;

    initial
    begin
        tx_clk_o = 1'h0;
        rx_clk_o = 1'h0;
        rxd_o = 4'h5;
        rx_dv_o = 1'h0;
        rx_er_o = 1'h1;
    end
    // link clocks start off the system clock edges
    initial
    begin
        #1.1;
        forever #7.5 tx_clk_o = ~tx_clk_o;
    end
    // slow receive clock, the design needs it at 25 MHz or less
    initial
    begin
        #1.7;
        forever #20 rx_clk_o = ~rx_clk_o;
    end

    always @(negedge tx_en_i) falls++;

    // write frame data as seen on the line at rising mdc
    always @(posedge mdc_i)
    begin
        if (mdio_oe_i)
            wsh = {wsh[14:0], mdio_o_i};
    end

    always @(posedge tx_clk_o)
    begin
        if (tx_en_i)
        begin
            sh = mode_i ? {txd_i, sh[15:4]} : {txd_i[0], sh[15:1]};
            hi_seen = hi_seen | (~mode_i & (|txd_i[3:1]));
            er_seen = er_seen | tx_er_i;
            units++;
        end
    end

    // one byte as one frame; idle lines show the inverse of the last value
    task automatic send(input logic m, input logic [7:0] b, input logic er);
        @(negedge rx_clk_o);
        rx_dv_o = 1'h1;
        rx_er_o = er;
        for (int i = 0; i < (m ? 2 : 8); i++)
        begin
            rxd_o = m ? b[4*i +: 4] : {{3{~b[i]}}, b[i]};
            @(negedge rx_clk_o);
        end
        rx_dv_o = 1'h0;
        rx_er_o = 1'h1;
        rxd_o = ~rxd_o;
    endtask : send

    always @(negedge mdc_i or posedge mdio_oe_i)
    begin
        if (mdio_oe_i)
            mcnt <= 0;
        else
            mcnt <= mcnt + 1;
    end
    // released line: a zero after the first falling mdc, then RD_VAL over the next 16, else the pull-up level
    assign mdio_o = mdio_oe_i ? mdio_o_i : (mcnt == 1) ? 1'h0 :
        (mcnt >= 2 && mcnt <= 17) ? RD_VAL[17 - mcnt] : 1'h1;
endmodule : phy_model

`default_nettype wire

//--- tb/test_mii_phy_side_interface.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            n_mismatch++; \
            $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
        end \
    end

module test_mii_phy_side_interface;
    logic        mclk_i, rstn_i, controller_enable_i, interface_pin_select_i;
    logic        mii_mode_i, full_duplex_i, tx_valid_i, tx_last_i, tx_err_i;
    logic        mgmt_start_i, mgmt_read_i, tx_clk_i, rx_clk_i, rx_dv_i;
    logic        rx_er_i, crs_i, col_i, mdio_i, tx_ready_o, rx_valid_o;
    logic        rx_end_o, rx_err_o, crs_o, col_o, mgmt_busy_o, mgmt_done_o;
    logic        tx_en_o, tx_en_oe_o, tx_er_o, pins_oe_o, mdc_o, mdio_o;
    logic        mdio_oe_o;
    logic [7:0]  tx_data_i, rx_data_o;
    logic [4:0]  mgmt_phy_i, mgmt_reg_i;
    logic [15:0] mgmt_wdata_i, mgmt_rdata_o;
    logic [3:0]  rxd_i, txd_o;
    int          n_checks = 0;
    int          n_mismatch = 0;
    // {tx error, four-bit mode, byte}
    logic [9:0]  rows [4] = '{10'h3A5, 10'h13C, 10'h096, 10'h001};

    mii_phy_side_interface dut (
        .mclk_i, .rstn_i, .controller_enable_i, .interface_pin_select_i,
        .mii_mode_i, .full_duplex_i, .tx_valid_i, .tx_data_i, .tx_last_i,
        .tx_err_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_end_o,
        .rx_err_o, .crs_o, .col_o, .mgmt_start_i, .mgmt_read_i, .mgmt_phy_i,
        .mgmt_reg_i, .mgmt_wdata_i, .mgmt_busy_o, .mgmt_done_o,
        .mgmt_rdata_o, .tx_clk_i, .txd_o, .tx_en_o, .tx_en_oe_o, .tx_er_o,
        .pins_oe_o, .rx_clk_i, .rxd_i, .rx_dv_i, .rx_er_i, .crs_i, .col_i,
        .mdc_o, .mdio_o, .mdio_oe_o, .mdio_i
    );

    // undriven transmit enable sits on its pull-down
    phy_model phy (
        .mode_i(mii_mode_i), .txd_i(txd_o), .tx_en_i(tx_en_oe_o & tx_en_o),
        .tx_er_i(tx_er_o), .mdc_i(mdc_o), .mdio_o_i(mdio_o),
        .mdio_oe_i(mdio_oe_o), .tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i),
        .rxd_o(rxd_i), .rx_dv_o(rx_dv_i), .rx_er_o(rx_er_i), .mdio_o(mdio_i)
    );

    always #2.5 mclk_i = ~mclk_i;

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic wait_rx();
        for (int k = 0; k < 200; k++)
        begin
            @(posedge mclk_i);
            if (rx_valid_o === 1'h1)
                return;
        end
        `CHK("rx word arrival", 1'h1, 1'h0)
    endtask : wait_rx

    task automatic row(input logic [9:0] r);
        int n;
        n = r[8] ? 2 : 8;
        @(negedge mclk_i);
        mii_mode_i = r[8];
        phy.units = 0;
        phy.hi_seen = 1'h0;
        phy.er_seen = 1'h0;
        tx_data_i = r[7:0];
        tx_err_i = r[9];
        tx_valid_i = 1'h1;
        for (int k = 0; k < 200; k++)
        begin
            @(posedge mclk_i);
            if (tx_ready_o === 1'h1)
                break;
        end
        @(negedge mclk_i);
        tx_valid_i = 1'h0;
        for (int k = 0; k < 400; k++)
        begin
            @(negedge mclk_i);
            if (phy.units == n && tx_en_o === 1'h0)
                break;
        end
        `CHK("tx byte", r[7:0], phy.sh[15:8])
        `CHK("tx unit count", n, phy.units)
        `CHK("tx upper lines", 1'h0, phy.hi_seen)
        `CHK("tx error line", r[9] & r[8], phy.er_seen)
        fork
            phy.send(r[8], r[7:0], r[9]);
            begin
                wait_rx();
                `CHK("rx byte", r[7:0], rx_data_o)
                `CHK("rx data word end", 1'h0, rx_end_o)
                wait_rx();
                `CHK("rx frame end", 1'h1, rx_end_o)
                `CHK("rx frame error", r[9], rx_err_o)
            end
        join
    endtask : row

    initial
    begin
        #400000;
        n_mismatch++;
        results();
    end

    initial
    begin
        mclk_i = 1'h0;
        rstn_i = 1'h0;
        controller_enable_i = 1'h1;
        interface_pin_select_i = 1'h0;
        mii_mode_i = 1'h1;
        full_duplex_i = 1'h0;
        tx_valid_i = 1'h0;
        tx_data_i = 8'h00;
        tx_last_i = 1'h1;
        tx_err_i = 1'h0;
        mgmt_start_i = 1'h0;
        mgmt_read_i = 1'h0;
        mgmt_phy_i = 5'h03;
        mgmt_reg_i = 5'h11;
        mgmt_wdata_i = 16'h5A3C;
        crs_i = 1'h0;
        col_i = 1'h0;
        // long enough for four edges of the slow link clock
        repeat (40) @(negedge mclk_i);
        rstn_i = 1'h1;
        repeat (4) @(negedge mclk_i);
        `CHK("tx enable driven", 1'h0, tx_en_oe_o)
        `CHK("shared pins owned", 1'h0, pins_oe_o)
        interface_pin_select_i = 1'h1;
        repeat (4) @(negedge mclk_i);
        `CHK("tx enable driven", 1'h1, tx_en_oe_o)
        `CHK("shared pins owned", 1'h1, pins_oe_o)
        foreach (rows[i])
            row(rows[i]);
        // two-byte serial frame: tx_en must bridge the byte boundary
        @(negedge mclk_i);
        mii_mode_i = 1'h0;
        phy.units = 0;
        phy.falls = 0;
        tx_last_i = 1'h0;
        for (int b = 0; b < 2; b++)
        begin
            tx_data_i = b[0] ? 8'hB4 : 8'h69;
            tx_valid_i = 1'h1;
            for (int k = 0; k < 200; k++)
            begin
                @(posedge mclk_i);
                if (tx_ready_o === 1'h1)
                    break;
            end
            @(negedge mclk_i);
            tx_last_i = 1'h1;
        end
        tx_valid_i = 1'h0;
        repeat (80) @(negedge mclk_i);
        `CHK("tx frame bits", 16'hB469, phy.sh)
        `CHK("tx frame units", 16, phy.units)
        `CHK("tx enable falls", 1, phy.falls)
        // management needs the four-bit mode back
        mii_mode_i = 1'h1;
        @(negedge mclk_i);
        for (int op = 1; op >= 0; op--)
        begin
            mgmt_read_i = op[0];
            mgmt_start_i = 1'h1;
            @(negedge mclk_i);
            mgmt_start_i = 1'h0;
            @(negedge mclk_i);
            `CHK("mgmt busy", 1'h1, mgmt_busy_o)
            for (int k = 0; k < 6000; k++)
            begin
                @(posedge mclk_i);
                if (mgmt_done_o === 1'h1)
                    break;
            end
            `CHK("mgmt done", 1'h1, mgmt_done_o)
            if (op == 1)
                `CHK("mgmt read data", 16'hC35A, mgmt_rdata_o)
            else
                `CHK("mgmt write data", 16'h5A3C, phy.wsh)
            @(negedge mclk_i);
        end
        mii_mode_i = 1'h0;
        mgmt_start_i = 1'h1;
        @(negedge mclk_i);
        mgmt_start_i = 1'h0;
        repeat (2) @(negedge mclk_i);
        `CHK("mgmt busy in serial mode", 1'h0, mgmt_busy_o)
        mii_mode_i = 1'h1;
        crs_i = 1'h1;
        col_i = 1'h1;
        full_duplex_i = 1'h1;
        repeat (8) @(negedge mclk_i);
        `CHK("collision in full duplex", 1'h0, col_o)
        `CHK("carrier sense", 1'h1, crs_o)
        full_duplex_i = 1'h0;
        repeat (8) @(negedge mclk_i);
        `CHK("collision in half duplex", 1'h1, col_o)
        results();
    end
endmodule : test_mii_phy_side_interface

`default_nettype wire
